//--- preamp_front_panel_control.sv
// front-panel control logic of the current preamplifier: autozero, reference clock, relays, overloads
// Functional notes
// - autozero on waits for next reference rising edge, at most 3.3 s, then engages.
// - autozero off samples and stores the trim within 1 s, then stops switching.
// - the stored trim stays applied until autozero is engaged again.
// - autozero switching toggles at half the selected reference clock frequency.
// - periodic signal on sync connector set as input is the external clock; LED lit.
// - external clock 0.90 to 1.10 Hz locks, after about 250 s.
// - unlocked LED lit while following external clock without lock.
// - no external clock: internal reference used, external and unlocked LEDs dark.
// - sync button toggles connector direction; output drives internal 1 Hz clock, LED lit.
// - output request with external clock present is refused and raises an error.
// - connector set to output ignores any applied external signal.
// - input button toggles input relay; LED lit while input open.
// - shield button cycles program, bias, ground with one of three LEDs.
// - bias button toggles bias terminal or ground; LED lit on ground.
// - grounded bias bypasses the difference amplifier.
// - bias-shield button toggles float or ground with one of two LEDs.
// - bias comparator overload lights the bias overload indicator.
// - overload indicators stay lit at least 50 ms, then clear once condition gone.
// - final or raw stage overload lights output indicator; source readable.
// - settings saved to non-volatile memory and restored at power-up.
// - when armed, overload or unlocked also asserts the status output.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module preamp_front_panel_control #(
  parameter int TRIM_W = 16,
  parameter int CAL_W = 16,
  parameter int unsigned AZ_WAIT = pfp_pkg::AZ_WAIT_CYC,
  parameter int unsigned AZ_SAMPLE = pfp_pkg::AZ_SAMPLE_CYC,
  parameter int unsigned OVERLOAD_SOURCE_QUERY_HOLD = pfp_pkg::OVERLOAD_SOURCE_QUERY_HOLD_CYC,
  parameter int unsigned DEB = pfp_pkg::DEBOUNCE_CYC,
  parameter int unsigned INT_HALF = pfp_pkg::INT_HALF_CYC,
  parameter int unsigned PER_MIN = pfp_pkg::EXT_PER_MIN_CYC,
  parameter int unsigned PER_MAX = pfp_pkg::EXT_PER_MAX_CYC,
  parameter int unsigned EXT_LOSS = pfp_pkg::EXT_LOSS_CYC,
  parameter int unsigned LOCK_N = pfp_pkg::LOCK_EDGES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [pfp_pkg::NB-1:0] btn_i,
  input wire logic sync_in_i,
  output logic sync_o,
  output logic sync_oe_o,
  input wire logic bias_cmp_i,
  input wire logic out_cmp_i,
  input wire logic raw_cmp_i,
  input wire logic [TRIM_W-1:0] trim_i,
  output logic [TRIM_W-1:0] trim_o,
  output logic az_switch_o,
  output logic az_led_o,
  output logic ext_led_o,
  output logic unlocked_led_o,
  output logic sync_out_led_o,
  output logic input_open_o,
  output logic [1:0] shield_sel_o,
  output logic shield_prog_led_o,
  output logic shield_bias_led_o,
  output logic shield_gnd_led_o,
  output logic bias_gnd_o,
  output logic diff_bypass_o,
  output logic bshield_float_led_o,
  output logic bshield_gnd_led_o,
  output logic bias_overload_indicator_o,
  output logic output_overload_indicator_o,
  output logic status_n_o,
  output logic [1:0] gain_o,
  output logic line_frequency_setting_o,
  output logic pll_keep_o,
  output logic [CAL_W-1:0] cal_o,
  input wire logic nv_load_i,
  input wire logic [CAL_W+9:0] nv_data_i,
  output logic nv_store_o,
  output logic [CAL_W+9:0] nv_data_o,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);
  import pfp_pkg::*;
  typedef struct packed {
    logic [NB-1:0] b_s1, b_s2, b_st, press;
    logic [NB-1:0][31:0] b_cnt;
    logic x_s1, x_s2, x_s3;
    logic [2:0] c_s1, c_s2;
    logic int_ref, ext_present, locked;
    logic [31:0] int_cnt, per_cnt, lock_cnt, az_cnt, rdata;
    az_state_t az_st;
    logic az_phase, az_want;
    logic [TRIM_W-1:0] trim_r, trim_o;
    logic lf50, input_open, bias_gnd, bshield_gnd, pll_keep, sync_out, arm;
    logic [1:0] gain, shield, ov;
    logic [CAL_W-1:0] cal;
    logic [1:0][31:0] ov_cnt;
    logic src_fin, src_raw, dde, ack, nv_store, status_n;
    logic [CAL_W+9:0] nv_data;
  } state_t;
  state_t s_r, s_nxt;
  logic int_rise, ext_rise, ref_rise, req, wr_go, unlocked;
  logic [1:0] ov_cond;
  // edge sources; the connector is deaf while driving out
  // ignore when output
  assign ext_rise = s_r.x_s2 & ~s_r.x_s3 & ~s_r.sync_out;
  assign int_rise = (s_r.int_cnt >= INT_HALF - 1) & ~s_r.int_ref;
  assign ref_rise = s_r.ext_present ? ext_rise : int_rise;
  assign unlocked = s_r.ext_present & ~s_r.locked;
  assign req = read_i | write_i;
  assign wr_go = write_i & s_r.ack;
  assign ov_cond = {s_r.c_s2[1] | s_r.c_s2[2], s_r.c_s2[0]};
  // next-state logic of the whole block
  always_comb begin
    logic dir_tgt;
    dir_tgt = s_r.sync_out;
    s_nxt = s_r;
    // two-flop synchronisers; first stage feeds only the second
    s_nxt.b_s1 = btn_i;
    s_nxt.b_s2 = s_r.b_s1;
    s_nxt.x_s1 = sync_in_i;
    s_nxt.x_s2 = s_r.x_s1;
    s_nxt.x_s3 = s_r.x_s2;
    s_nxt.c_s1 = {raw_cmp_i, out_cmp_i, bias_cmp_i};
    s_nxt.c_s2 = s_r.c_s1;
    s_nxt.press = '0;
    for (int i = 0; i < NB; i++) begin
      if (s_r.b_s2[i] == s_r.b_st[i]) begin
        s_nxt.b_cnt[i] = '0;
      end else if (s_r.b_cnt[i] >= DEB - 1) begin
        s_nxt.b_st[i] = s_r.b_s2[i];
        s_nxt.b_cnt[i] = '0;
        s_nxt.press[i] = s_r.b_s2[i];
      end else begin
        s_nxt.b_cnt[i] = s_r.b_cnt[i] + 32'h1;
      end
    end
    if (s_r.int_cnt >= INT_HALF - 1) begin
      s_nxt.int_cnt = '0;
      s_nxt.int_ref = ~s_r.int_ref;
    end else begin
      s_nxt.int_cnt = s_r.int_cnt + 32'h1;
    end
    if (s_r.sync_out) begin
      s_nxt.ext_present = 1'b0;
      s_nxt.locked = 1'b0;
      s_nxt.lock_cnt = '0;
      s_nxt.per_cnt = '0;
    end else if (ext_rise) begin
      s_nxt.per_cnt = '0;
      s_nxt.ext_present = 1'b1;
      if (s_r.ext_present && s_r.per_cnt >= PER_MIN - 1 && s_r.per_cnt <= PER_MAX - 1) begin
        if (s_r.lock_cnt >= LOCK_N - 1) begin
          s_nxt.locked = 1'b1;
        end else begin
          s_nxt.lock_cnt = s_r.lock_cnt + 32'h1;
        end
      end else begin
        s_nxt.lock_cnt = '0;
        s_nxt.locked = 1'b0;
      end
    end else if (s_r.per_cnt >= EXT_LOSS - 1) begin
      s_nxt.ext_present = 1'b0;
      s_nxt.locked = 1'b0;
      s_nxt.lock_cnt = '0;
    end else begin
      s_nxt.per_cnt = s_r.per_cnt + 32'h1;
    end
    if (nv_load_i) begin
      {s_nxt.cal, s_nxt.pll_keep, s_nxt.bshield_gnd, s_nxt.bias_gnd, s_nxt.shield, s_nxt.input_open,
       s_nxt.az_want, s_nxt.gain, s_nxt.lf50} = nv_data_i;
    end
    // settings written by software, low and high byte lanes
    if (wr_go && address_i == REG_SETTINGS && byteenable_i[0]) begin
      s_nxt.lf50 = writedata_i[SET_LF];
      s_nxt.gain = writedata_i[SET_GAIN +: 2];
      s_nxt.az_want = writedata_i[SET_AZ];
      s_nxt.input_open = writedata_i[SET_INOPEN];
      if (writedata_i[SET_SHIELD +: 2] <= SHIELD_GND) begin
        s_nxt.shield = writedata_i[SET_SHIELD +: 2];
      end
      s_nxt.bias_gnd = writedata_i[SET_BIASGND];
    end
    if (wr_go && address_i == REG_SETTINGS && byteenable_i[1]) begin
      s_nxt.bshield_gnd = writedata_i[SET_BSHGND];
      s_nxt.pll_keep = writedata_i[SET_PLL];
      s_nxt.arm = writedata_i[SET_ARM];
    end
    if (wr_go && address_i == REG_CAL) begin
      if (byteenable_i[0]) s_nxt.cal[7:0] = writedata_i[7:0];
      if (byteenable_i[1]) s_nxt.cal[CAL_W-1:8] = writedata_i[CAL_W-1:8];
    end
    // front-panel toggles
    if (s_r.press[BTN_AZ]) s_nxt.az_want = ~s_r.az_want;
    if (s_r.press[BTN_INPUT]) s_nxt.input_open = ~s_r.input_open;
    if (s_r.press[BTN_SHIELD]) begin
      s_nxt.shield = (s_r.shield == SHIELD_PROG) ? SHIELD_BIAS :
                     (s_r.shield == SHIELD_BIAS) ? SHIELD_GND : SHIELD_PROG;
    end
    if (s_r.press[BTN_BIAS]) s_nxt.bias_gnd = ~s_r.bias_gnd;
    if (s_r.press[BTN_BSH]) s_nxt.bshield_gnd = ~s_r.bshield_gnd;
    // direction target from button toggle or software write
    if (s_r.press[BTN_SYNC]) dir_tgt = ~s_r.sync_out;
    if (wr_go && address_i == REG_SETTINGS && byteenable_i[1]) dir_tgt = writedata_i[SET_SYNCOUT];
    // error flag: clear first so a new refusal in the same cycle wins
    if (wr_go && address_i == REG_STATUS && byteenable_i[1] && writedata_i[ST_DDE]) s_nxt.dde = 1'b0;
    // refuse output while external clock present
    if (dir_tgt && !s_r.sync_out && s_r.ext_present) begin
      s_nxt.sync_out = 1'b0;
      s_nxt.dde = 1'b1;
    end else begin
      s_nxt.sync_out = dir_tgt;
    end
    // autozero sequencing
    unique case (s_r.az_st)
      AZ_OFF: begin
        s_nxt.az_phase = 1'b0;
        if (s_r.az_want) begin
          s_nxt.az_st = AZ_ARM;
          s_nxt.az_cnt = '0;
        end
      end
      AZ_ARM: begin
        if (!s_r.az_want) begin
          s_nxt.az_st = AZ_OFF;
        end else if (ref_rise || s_r.az_cnt >= AZ_WAIT - 1) begin
          s_nxt.az_st = AZ_ON;
          s_nxt.az_phase = 1'b0;
        end else begin
          s_nxt.az_cnt = s_r.az_cnt + 32'h1;
        end
      end
      AZ_ON: begin
        if (!s_r.az_want) begin
          s_nxt.az_st = AZ_HOLD;
          s_nxt.az_cnt = '0;
        end
        if (ref_rise) s_nxt.az_phase = ~s_r.az_phase;
      end
      AZ_HOLD: begin
        if (s_r.az_cnt >= AZ_SAMPLE - 1) begin
          s_nxt.trim_r = trim_i;
          s_nxt.az_st = AZ_OFF;
        end else begin
          s_nxt.az_cnt = s_r.az_cnt + 32'h1;
        end
        if (ref_rise) s_nxt.az_phase = ~s_r.az_phase;
      end
    endcase
    // live trim while zeroing, held value otherwise
    s_nxt.trim_o = (s_r.az_st == AZ_ON || s_r.az_st == AZ_HOLD) ? trim_i : s_r.trim_r;
    for (int k = 0; k < 2; k++) begin
      if (!s_r.ov[k]) begin
        if (ov_cond[k]) begin
          s_nxt.ov[k] = 1'b1;
          s_nxt.ov_cnt[k] = '0;
        end
      end else if (s_r.ov_cnt[k] < OVERLOAD_SOURCE_QUERY_HOLD - 1) begin
        s_nxt.ov_cnt[k] = s_r.ov_cnt[k] + 32'h1;
      end else if (!ov_cond[k]) begin
        s_nxt.ov[k] = 1'b0;
      end
    end
    // sticky source flags, a new event beats the clear
    if (wr_go && address_i == REG_STATUS && byteenable_i[0] && writedata_i[ST_SRC_FIN]) s_nxt.src_fin = 1'b0;
    if (wr_go && address_i == REG_STATUS && byteenable_i[1] && writedata_i[ST_SRC_RAW]) s_nxt.src_raw = 1'b0;
    if (s_r.c_s2[1]) s_nxt.src_fin = 1'b1;
    if (s_r.c_s2[2]) s_nxt.src_raw = 1'b1;
    s_nxt.status_n = ~(s_r.arm & ((|s_r.ov) | unlocked));
    // bus slave: one wait cycle, read data captured with the answer
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack) begin
      unique case (address_i)
        REG_SETTINGS: s_nxt.rdata = {20'h0, s_r.arm, s_r.sync_out, s_r.pll_keep, s_r.bshield_gnd, s_r.bias_gnd,
                                     s_r.shield, s_r.input_open, s_r.az_want, s_r.gain, s_r.lf50};
        REG_STATUS: s_nxt.rdata = {21'h0, s_r.az_phase, s_r.dde, s_r.src_raw, s_r.src_fin, s_r.ov, s_r.sync_out,
                                   unlocked, s_r.ext_present, s_r.az_st == AZ_ARM || s_r.az_st == AZ_HOLD,
                                   s_r.az_st == AZ_ON};
        REG_TRIM: s_nxt.rdata = {{(32 - TRIM_W){1'b0}}, s_r.trim_r};
        REG_CAL: s_nxt.rdata = {{(32 - CAL_W){1'b0}}, s_r.cal};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // save on any change of retained settings
    s_nxt.nv_data = {s_nxt.cal, s_nxt.pll_keep, s_nxt.bshield_gnd, s_nxt.bias_gnd, s_nxt.shield,
                     s_nxt.input_open, s_nxt.az_want, s_nxt.gain, s_nxt.lf50};
    s_nxt.nv_store = (s_nxt.nv_data != s_r.nv_data);
    // synchronous reset to the default configuration
    if (!rst_n_i) begin
      s_nxt = '0;
      s_nxt.az_st = AZ_OFF;
      s_nxt.gain = GAIN_RST;
      s_nxt.az_want = AZ_RST;
      s_nxt.shield = SHIELD_GND;
      s_nxt.bias_gnd = BIASGND_RST;
      s_nxt.bshield_gnd = BSHGND_RST;
      s_nxt.status_n = 1'b1;
      s_nxt.nv_data = {{CAL_W{1'b0}}, 1'b0, BSHGND_RST, BIASGND_RST, SHIELD_GND, 1'b0, AZ_RST, GAIN_RST, 1'b0};
    end
  end
  // the single state register
  always_ff @(posedge clock_i) begin
    s_r <= s_nxt;
  end
  // outputs straight from state bits, except waitrequest_o, which also decodes read_i and write_i
  assign sync_o = s_r.int_ref;
  assign sync_oe_o = s_r.sync_out;
  assign sync_out_led_o = s_r.sync_out;
  assign trim_o = s_r.trim_o;
  assign az_switch_o = s_r.az_phase;
  assign az_led_o = (s_r.az_st == AZ_ON || s_r.az_st == AZ_HOLD); // stays lit until the trim is stored
  assign ext_led_o = s_r.ext_present;
  assign unlocked_led_o = unlocked;
  assign input_open_o = s_r.input_open;
  assign shield_sel_o = s_r.shield;
  assign shield_prog_led_o = (s_r.shield == SHIELD_PROG);
  assign shield_bias_led_o = (s_r.shield == SHIELD_BIAS);
  assign shield_gnd_led_o = (s_r.shield == SHIELD_GND);
  assign bias_gnd_o = s_r.bias_gnd;
  assign diff_bypass_o = s_r.bias_gnd;
  assign bshield_float_led_o = ~s_r.bshield_gnd;
  assign bshield_gnd_led_o = s_r.bshield_gnd;
  assign bias_overload_indicator_o = s_r.ov[0];
  assign output_overload_indicator_o = s_r.ov[1];
  assign status_n_o = s_r.status_n;
  assign gain_o = s_r.gain;
  assign line_frequency_setting_o = s_r.lf50;
  assign pll_keep_o = s_r.pll_keep;
  assign cal_o = s_r.cal;
  assign nv_store_o = s_r.nv_store;
  assign nv_data_o = s_r.nv_data;
  assign readdata_o = s_r.rdata;
  assign waitrequest_o = req & ~s_r.ack;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_az_wait;
    (s_r.az_st == AZ_ARM && s_r.az_want && ref_rise) |=> (s_r.az_st == AZ_ON && az_led_o);
  endproperty
  a_az_wait: assert property (p_az_wait) else $error("autozero did not engage on reference edge");
  property p_az_bound;
    (s_r.az_st == AZ_ARM) |-> (s_r.az_cnt < AZ_WAIT);
  endproperty
  a_az_bound: assert property (p_az_bound) else $error("autozero wait exceeded its limit");
  property p_az_store;
    (s_r.az_st == AZ_HOLD && s_r.az_cnt >= AZ_SAMPLE - 1) |=> (s_r.az_st == AZ_OFF && s_r.trim_r == $past(trim_i));
  endproperty
  a_az_store: assert property (p_az_store) else $error("trim not stored on autozero off");
  property p_trim_hold;
    (s_r.az_st == AZ_OFF) |=> (trim_o == $past(s_r.trim_r));
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("held trim not applied");
  property p_half_rate;
    (s_r.az_st == AZ_ON && s_r.az_want && ref_rise) |=> (az_switch_o != $past(az_switch_o));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("switch did not toggle on reference edge");
  property p_refuse;
    (s_r.press[BTN_SYNC] && !s_r.sync_out && s_r.ext_present) |=> (!sync_oe_o && s_r.dde);
  endproperty
  a_refuse: assert property (p_refuse) else $error("output direction not refused");
  property p_ignore;
    (sync_oe_o && $past(sync_oe_o)) |-> (!ext_led_o && !unlocked_led_o);
  endproperty
  a_ignore: assert property (p_ignore) else $error("external clock seen while driving out");
  property p_overload_source_query_min;
    $rose(bias_overload_indicator_o) |-> bias_overload_indicator_o[*8];
  endproperty
  a_overload_source_query_min: assert property (p_overload_source_query_min) else $error("bias overload indicator cleared too soon");
  property p_status;
    (s_r.arm && (bias_overload_indicator_o || unlocked_led_o)) |=> !status_n_o;
  endproperty
  a_status: assert property (p_status) else $error("status not asserted while armed");
  property p_press_once;
    s_r.press[BTN_INPUT] |=> (!s_r.press[BTN_INPUT] && input_open_o != $past(input_open_o));
  endproperty
  a_press_once: assert property (p_press_once) else $error("input press not acted on once");
endmodule
`default_nettype wire

//--- pfp_pkg.sv
// shared constants, register map and types of the preamp front-panel control block
package pfp_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // times in their own units, cycle counts derived from them
  localparam int unsigned AZ_WAIT_MS = 3300;
  localparam int unsigned AZ_WAIT_CYC = AZ_WAIT_MS * CYC_PER_MS;
  localparam int unsigned AZ_SAMPLE_MS = 500;
  localparam int unsigned AZ_SAMPLE_CYC = AZ_SAMPLE_MS * CYC_PER_MS;
  localparam int unsigned OVERLOAD_SOURCE_QUERY_HOLD_MS = 50;
  localparam int unsigned OVERLOAD_SOURCE_QUERY_HOLD_CYC = OVERLOAD_SOURCE_QUERY_HOLD_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned INT_REF_MHZ = 1000;
  localparam int unsigned INT_HALF_CYC = 32'(64'(CLK_HZ) * 500 / INT_REF_MHZ);
  localparam int unsigned EXT_FMIN_MHZ = 900;
  localparam int unsigned EXT_FMAX_MHZ = 1100;
  localparam int unsigned EXT_PER_MIN_CYC = 32'((64'(CLK_HZ) * 1000 + EXT_FMAX_MHZ - 1) / EXT_FMAX_MHZ);
  localparam int unsigned EXT_PER_MAX_CYC = 32'(64'(CLK_HZ) * 1000 / EXT_FMIN_MHZ);
  localparam int unsigned EXT_LOSS_CYC = 2 * EXT_PER_MAX_CYC;
  localparam int unsigned LOCK_S = 250;
  localparam int unsigned LOCK_EDGES = LOCK_S * INT_REF_MHZ / 1000;
  // register byte offsets
  localparam logic [4:0] REG_SETTINGS = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_TRIM = 5'h08;
  localparam logic [4:0] REG_CAL = 5'h0c;
  // settings field positions
  localparam int SET_LF = 0;
  localparam int SET_GAIN = 1;
  localparam int SET_AZ = 3;
  localparam int SET_INOPEN = 4;
  localparam int SET_SHIELD = 5;
  localparam int SET_BIASGND = 7;
  localparam int SET_BSHGND = 8;
  localparam int SET_PLL = 9;
  localparam int SET_SYNCOUT = 10;
  localparam int SET_ARM = 11;
  // status field positions of the clearable bits
  localparam int ST_SRC_FIN = 7;
  localparam int ST_SRC_RAW = 8;
  localparam int ST_DDE = 9;
  // input shield codes and reset defaults
  localparam logic [1:0] SHIELD_PROG = 2'h0;
  localparam logic [1:0] SHIELD_BIAS = 2'h1;
  localparam logic [1:0] SHIELD_GND = 2'h2;
  localparam logic [1:0] GAIN_RST = 2'h0;
  localparam logic AZ_RST = 1'h1;
  localparam logic BIASGND_RST = 1'h1;
  localparam logic BSHGND_RST = 1'h1;
  // front-panel button indices
  localparam int NB = 6;
  localparam int BTN_AZ = 0;
  localparam int BTN_SYNC = 1;
  localparam int BTN_INPUT = 2;
  localparam int BTN_SHIELD = 3;
  localparam int BTN_BIAS = 4;
  localparam int BTN_BSH = 5;
  typedef enum logic [1:0] {AZ_OFF, AZ_ARM, AZ_ON, AZ_HOLD} az_state_t;
endpackage

//--- ref_clock_source.sv
// far-side model: external reference clock source on the rear sync connector
`timescale 1ns/1ns
`default_nettype none
module ref_clock_source #(
  parameter int HALF = 50
) (
  input wire logic clock_i,
  input wire logic en_i,
  output logic ext_o
);
  int cnt_r;
  always_ff @(posedge clock_i) begin
    if (!en_i) begin
      cnt_r <= 0;
      ext_o <= 1'b0; // unplugged source leaves the line pulled low
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      ext_o <= !ext_o;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench of the preamp front-panel control
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pfp_pkg::*;
  localparam int LIMIT = 20000;
  // shortened counts so every timed path fits in the run
  localparam int unsigned AZW = 200, AZS = 20, OVH = 16, DBN = 4, IHALF = 50;
  localparam int unsigned PMIN = 90, PMAX = 110, LOSS = 220, LOCKN = 3;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] btn_i = 6'h0;
  logic bias_cmp_i = 1'b0, out_cmp_i = 1'b0, raw_cmp_i = 1'b0, nv_load_i = 1'b0, ext_en = 1'b0;
  logic read_i = 1'b0, write_i = 1'b0;
  logic [3:0] byteenable_i = 4'hf;
  logic [15:0] trim_i = 16'h0;
  logic [25:0] nv_data_i = 26'h0;
  logic [25:0] nv_data_o;
  logic [4:0] address_i = 5'h0;
  logic [31:0] writedata_i = 32'h0, rd;
  logic sync_o, sync_oe_o, ext_sig, az_switch_o, az_led_o, ext_led_o, unlocked_led_o, sync_out_led_o;
  logic input_open_o, shield_prog_led_o, shield_bias_led_o, shield_gnd_led_o, bias_gnd_o, diff_bypass_o;
  logic bshield_float_led_o, bshield_gnd_led_o, bias_overload_indicator_o, output_overload_indicator_o;
  logic status_n_o, line_frequency_setting_o, pll_keep_o, waitrequest_o, nv_store_o;
  logic [1:0] shield_sel_o, gain_o;
  logic [15:0] trim_o, cal_o;
  logic [31:0] readdata_o;
  logic [4:0] exp_sh [3] = '{5'h04, 5'h0a, 5'h11};
  int fail_count = 0, tests_run = 0, cyc = 0, k;
  // connector level: the driving side wins while the block outputs
  wire logic sync_in_i = sync_oe_o ? sync_o : ext_sig;

  always #2 clock_i = ~clock_i;

  // block under test with shortened counts
  preamp_front_panel_control #(.AZ_WAIT(AZW), .AZ_SAMPLE(AZS), .OVERLOAD_SOURCE_QUERY_HOLD(OVH), .DEB(DBN), .INT_HALF(IHALF),
    .PER_MIN(PMIN), .PER_MAX(PMAX), .EXT_LOSS(LOSS), .LOCK_N(LOCKN)) preamp_front_panel_control_inst (
    .clock_i, .rst_n_i, .btn_i, .sync_in_i, .sync_o, .sync_oe_o, .bias_cmp_i, .out_cmp_i, .raw_cmp_i,
    .trim_i, .trim_o, .az_switch_o, .az_led_o, .ext_led_o, .unlocked_led_o, .sync_out_led_o,
    .input_open_o, .shield_sel_o, .shield_prog_led_o, .shield_bias_led_o, .shield_gnd_led_o,
    .bias_gnd_o, .diff_bypass_o, .bshield_float_led_o, .bshield_gnd_led_o, .bias_overload_indicator_o,
    .output_overload_indicator_o, .status_n_o, .gain_o, .line_frequency_setting_o, .pll_keep_o, .cal_o,
    .nv_load_i, .nv_data_i, .nv_store_o, .nv_data_o, .address_i, .read_i, .write_i,
    .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o);

  // default half period gives a 100-cycle reference, inside the lock window
  ref_clock_source ref_clock_source_inst (.clock_i(clock_i), .en_i(ext_en), .ext_o(ext_sig));

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    address_i <= a;
    write_i <= w;
    read_i <= !w;
    writedata_i <= d;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask

  // press held well past the debounce time, then released
  task automatic press(input int i);
    @(posedge clock_i);
    btn_i[i] <= 1'b1;
    repeat (12) @(posedge clock_i);
    btn_i[i] <= 1'b0;
    repeat (12) @(posedge clock_i);
  endtask

  // half period of sync_o (sel 1) or of the autozero switch (sel 0) into k
  task automatic measure(input logic sel);
    logic p;
    p = sel ? sync_o : az_switch_o;
    for (k = 0; k < 300 && (sel ? sync_o : az_switch_o) === p; k++) @(posedge clock_i);
    for (k = 0; k < 300 && (sel ? sync_o : az_switch_o) !== p; k++) @(posedge clock_i);
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    bus(1'b0, REG_SETTINGS, 32'h0);
    chk(rd, 32'h1c8);
    chk({shield_gnd_led_o, bshield_gnd_led_o, bias_gnd_o, status_n_o}, 4'hf);
    chk({ext_led_o, unlocked_led_o}, 2'h0);
    for (k = 0; k < 260 && az_led_o !== 1'b1; k++) @(posedge clock_i);
    chk(az_led_o, 1'b1);
    measure(1'b0);
    chk(k > 96 && k < 104, 1'b1);
    press(BTN_INPUT);
    chk(input_open_o, 1'b1);
    press(BTN_INPUT);
    chk(input_open_o, 1'b0);
    press(BTN_BIAS);
    chk(bias_gnd_o, 1'b0);
    chk(diff_bypass_o, 1'b0);
    press(BTN_BSH);
    chk({bshield_float_led_o, bshield_gnd_led_o}, 2'h2);
    for (int i = 0; i < 3; i++) begin
      press(BTN_SHIELD);
      chk({shield_sel_o, shield_prog_led_o, shield_bias_led_o, shield_gnd_led_o}, exp_sh[i]);
    end
    bias_cmp_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    bias_cmp_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(bias_overload_indicator_o, 1'b1);
    repeat (10) @(posedge clock_i);
    chk(bias_overload_indicator_o, 1'b1);
    repeat (20) @(posedge clock_i);
    chk(bias_overload_indicator_o, 1'b0);
    bus(1'b1, REG_SETTINGS, 32'h848);
    raw_cmp_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(output_overload_indicator_o, 1'b1);
    chk(status_n_o, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[8:7], 2'h2);
    raw_cmp_i <= 1'b0;
    repeat (30) @(posedge clock_i);
    chk({output_overload_indicator_o, status_n_o}, 2'h1);
    // final-stage overload, then a low-lane clear of its source flag only
    out_cmp_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(output_overload_indicator_o, 1'b1);
    out_cmp_i <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[8:7], 2'h3);
    byteenable_i <= 4'h1;
    bus(1'b1, REG_STATUS, 32'h180);
    byteenable_i <= 4'hf;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[8:7], 2'h2);
    trim_i <= 16'h1234;
    press(BTN_AZ);
    for (k = 0; k < 60 && az_led_o !== 1'b0; k++) @(posedge clock_i);
    chk({az_led_o, trim_o}, {1'b0, 16'h1234});
    trim_i <= 16'h5678;
    repeat (150) @(posedge clock_i);
    chk({trim_o, az_switch_o}, {16'h1234, 1'b0});
    bus(1'b0, REG_TRIM, 32'h0);
    chk(rd, 32'h1234);
    ext_en <= 1'b1;
    repeat (120) @(posedge clock_i);
    chk(ext_led_o, 1'b1);
    chk(unlocked_led_o, 1'b1);
    chk(status_n_o, 1'b0);
    press(BTN_SYNC);
    chk(sync_oe_o, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[9], 1'b1);
    repeat (400) @(posedge clock_i);
    chk({ext_led_o, unlocked_led_o}, 2'h2);
    ext_en <= 1'b0;
    repeat (320) @(posedge clock_i);
    chk({ext_led_o, unlocked_led_o}, 2'h0);
    press(BTN_SYNC);
    chk({sync_oe_o, sync_out_led_o}, 2'h3);
    measure(1'b1);
    chk(k > 47 && k < 53, 1'b1);
    ext_en <= 1'b1;
    repeat (300) @(posedge clock_i);
    chk(ext_led_o, 1'b0);
    nv_load_i <= 1'b1;
    nv_data_i <= {16'habcd, 10'h203};
    @(posedge clock_i);
    nv_load_i <= 1'b0;
    @(posedge clock_i);
    chk({nv_store_o, nv_data_o}, {1'b1, 16'habcd, 10'h203});
    repeat (2) @(posedge clock_i);
    chk({cal_o, pll_keep_o, gain_o, line_frequency_setting_o}, {16'habcd, 1'b1, 2'h1, 1'b1});
    // unmapped place reads as zero
    bus(1'b0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
